// ### rtl/nimsk_irq.sv
// Interrupt status and mask registers with APB access and one interrupt line
//
// What this block does
// - With mask bit 7 set, a general-purpose timer wrap raises the interrupt; with it clear it does not.
// - With mask bit 6 set, running out of receive descriptors raises the interrupt.
// - With mask bit 5 set, running out of receive resource descriptors raises the interrupt.
// - With mask bit 4 set, storing past the end of the receive buffer area raises the interrupt.
// - With mask bit 3 set, a wrap of the CRC error tally counter raises the interrupt.
// - With mask bit 2 set, a wrap of the alignment error tally counter raises the interrupt.
// - With mask bit 1 set, a wrap of the missed-packet tally counter raises the interrupt.
// - With mask bit 0 set, a receive FIFO overrun raises the interrupt; with it clear it does not.
// - A set status bit drives the interrupt only while its mask bit is one.
// - Whenever the interrupt is active at least one status bit is set.
// - Writing one to a status bit clears it, and the host acknowledges each handled event so.
// - Writing zero to a status bit leaves it unchanged.
// - Hardware reset clears all status bits and software reset leaves them unchanged.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module nimsk_irq (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire nimsk_pkg::nimsk_apb_req_t apb_req,
  output nimsk_pkg::nimsk_apb_rsp_t apb_rsp,
  // Event pulses from the controller's units
  input wire nimsk_pkg::nimsk_events_t events,
  // Interrupt to the host and software reset pulse
  output logic irq,
  output logic sw_reset
);

  function automatic logic [nimsk_pkg::FLAG_W-1:0] lanes16(input logic [3:0] strb);
    lanes16 = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic [nimsk_pkg::FLAG_W-1:0] one_bit(input int unsigned pos);
    one_bit = nimsk_pkg::FLAG_W'(1) << pos;
  endfunction

  logic [nimsk_pkg::FLAG_W-1:0] interrupt_event_flags;
  logic [nimsk_pkg::FLAG_W-1:0] interrupt_enable_mask;
  logic [nimsk_pkg::FLAG_W-1:0] next_flags;
  logic [nimsk_pkg::FLAG_W-1:0] next_mask;
  logic [nimsk_pkg::FLAG_W-1:0] ev_bits;
  logic [nimsk_pkg::FLAG_W-1:0] wr_bits;
  logic [nimsk_pkg::FLAG_W-1:0] clr_bits;
  logic [nimsk_pkg::FLAG_W-1:0] rd_word;
  logic [nimsk_pkg::DATA_W-1:0] next_prdata;
  logic [nimsk_pkg::ADDR_W-1:0] reg_idx;
  logic access;
  logic done;
  logic hit_ctrl;
  logic hit_mask;
  logic hit_status;
  logic hit_pend;
  logic mapped;
  logic wr_done;
  logic next_pready;
  logic next_irq;
  logic next_sw_reset;

  // Address decode; byte offsets are word aligned
  assign reg_idx = {2'b00, apb_req.paddr[nimsk_pkg::ADDR_W-1:2]};
  assign access = apb_req.psel && apb_req.penable;
  assign done = access && apb_rsp.pready;
  assign wr_done = done && apb_req.pwrite;
  assign hit_ctrl = reg_idx == nimsk_pkg::IDX_CTRL;
  assign hit_mask = reg_idx == nimsk_pkg::IDX_MASK;
  assign hit_status = reg_idx == nimsk_pkg::IDX_STATUS;
  assign hit_pend = reg_idx == nimsk_pkg::IDX_PEND;
  assign mapped = hit_ctrl || hit_mask || hit_status || hit_pend;

  // One wait state: pready rises on the second access cycle
  assign next_pready = access && !apb_rsp.pready;

  // Write data limited to the two low byte lanes
  assign wr_bits = apb_req.pwdata[nimsk_pkg::FLAG_W-1:0] & lanes16(apb_req.pstrb);

  // Status bits layout, bit 15 held at zero
  // position mapping
  assign ev_bits = {1'b0, events} & nimsk_pkg::FLAGS_LIVE;

  // Write one to clear, zero has no effect
  // clear by one
  assign clr_bits = (wr_done && hit_status) ? wr_bits : '0;

  // A new event beats a clear in the same cycle so no event is lost
  // latch regardless of mask
  assign next_flags = ((interrupt_event_flags & ~clr_bits) | ev_bits) & nimsk_pkg::FLAGS_LIVE;

  assign next_mask = (wr_done && hit_mask) ?
    (((interrupt_enable_mask & ~lanes16(apb_req.pstrb)) | wr_bits) & nimsk_pkg::FLAGS_LIVE) :
    interrupt_enable_mask;

  // Interrupt follows the registers without lag, so it never outlives its source
  // mask gating
  assign next_irq = |(next_flags & next_mask);

  // Software reset is a pulse only; status and mask are deliberately untouched
  // soft reset keeps status
  assign next_sw_reset = wr_done && hit_ctrl && wr_bits[nimsk_pkg::BIT_CTRL_SW_RESET];

  // Read data is captured on the wait cycle and stands while pready is high
  assign rd_word = hit_mask ? interrupt_enable_mask :
                   hit_status ? interrupt_event_flags :
                   hit_pend ? (interrupt_event_flags & interrupt_enable_mask) : '0;
  assign next_prdata = (next_pready && !apb_req.pwrite) ? {16'h0000, rd_word} : apb_rsp.prdata;

  // Registers
  // hardware reset clears status
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      interrupt_event_flags <= nimsk_pkg::FLAGS_RESET;
      interrupt_enable_mask <= nimsk_pkg::MASK_RESET;
      irq <= 1'b0;
      sw_reset <= 1'b0;
    end else begin
      interrupt_event_flags <= next_flags;
      interrupt_enable_mask <= next_mask;
      irq <= next_irq;
      sw_reset <= next_sw_reset;
    end
  end

  // APB answer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= next_pready;
      apb_rsp.pslverr <= next_pready && !mapped;
      apb_rsp.prdata <= next_prdata;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_event_seen(int unsigned b);
    events[b] && next_mask[b];
  endsequence

  sequence s_lone_flag(int unsigned b);
    interrupt_event_flags == one_bit(b) && !interrupt_enable_mask[b];
  endsequence

  sequence s_ack_write(int unsigned b);
    wr_done && hit_status && wr_bits[b] && !events[b];
  endsequence

  property p_event_irq(int unsigned b);
    s_event_seen(b) |=> irq && interrupt_event_flags[b];
  endproperty

  property p_masked_quiet(int unsigned b);
    s_lone_flag(b) |-> !irq;
  endproperty

  property p_ack_clears(int unsigned b);
    s_ack_write(b) |=> !interrupt_event_flags[b];
  endproperty

  a_timer_wrap_irq: assert property (p_event_irq(nimsk_pkg::BIT_TIMER_WRAP))
    else $error("timer wrap did not interrupt");
  a_timer_wrap_quiet: assert property (p_masked_quiet(nimsk_pkg::BIT_TIMER_WRAP))
    else $error("masked timer wrap interrupted");
  a_desc_empty_irq: assert property (p_event_irq(nimsk_pkg::BIT_RX_DESC_EMPTY))
    else $error("descriptor exhaustion did not interrupt");
  a_resource_empty_irq: assert property (p_event_irq(nimsk_pkg::BIT_RX_RESOURCE_EMPTY))
    else $error("resource exhaustion did not interrupt");
  a_area_overrun_irq: assert property (p_event_irq(nimsk_pkg::BIT_RX_AREA_OVERRUN))
    else $error("buffer area overrun did not interrupt");
  a_crc_wrap_irq: assert property (p_event_irq(nimsk_pkg::BIT_CRC_TALLY_WRAP))
    else $error("crc tally wrap did not interrupt");
  a_align_wrap_irq: assert property (p_event_irq(nimsk_pkg::BIT_ALIGN_TALLY_WRAP))
    else $error("alignment tally wrap did not interrupt");
  a_missed_wrap_irq: assert property (p_event_irq(nimsk_pkg::BIT_MISSED_TALLY_WRAP))
    else $error("missed tally wrap did not interrupt");
  a_fifo_overrun_irq: assert property (p_event_irq(nimsk_pkg::BIT_RX_FIFO_OVERRUN))
    else $error("fifo overrun did not interrupt");
  a_fifo_overrun_quiet: assert property (p_masked_quiet(nimsk_pkg::BIT_RX_FIFO_OVERRUN))
    else $error("masked fifo overrun interrupted");

  a_irq_mask_gate: assert property (
    irq == |(interrupt_event_flags & interrupt_enable_mask))
    else $error("interrupt disagrees with masked status");

  a_irq_has_source: assert property (
    irq |-> interrupt_event_flags != '0)
    else $error("interrupt active with empty status");

  a_ack_clears_low: assert property (p_ack_clears(0))
    else $error("write one did not clear bit 0");
  a_ack_clears_high: assert property (p_ack_clears(14))
    else $error("write one did not clear bit 14");

  a_zero_write_keeps: assert property (
    (wr_done && hit_status) |=>
      (interrupt_event_flags & ~$past(wr_bits)) ==
        (($past(interrupt_event_flags) | $past(ev_bits)) & ~$past(wr_bits)))
    else $error("write zero changed a status bit");

  a_soft_reset_keeps: assert property (
    sw_reset |-> interrupt_event_flags == ($past(interrupt_event_flags) | $past(ev_bits)))
    else $error("software reset disturbed status");

  a_reserved_bit_zero: assert property (
    !interrupt_event_flags[nimsk_pkg::BIT_RESERVED] && !apb_rsp.prdata[nimsk_pkg::BIT_RESERVED])
    else $error("status bit 15 not zero");

  a_flag_holds_set: assert property (
    interrupt_event_flags[3] && !(wr_done && hit_status && wr_bits[3]) |=> interrupt_event_flags[3])
    else $error("status bit dropped without a clear");

  a_apb_one_wait: assert property (
    access && !apb_rsp.pready |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("apb answer not one wait state");

  // Read data is captured on the wait cycle and shown one edge later
  sequence s_read_wait;
    access && !apb_rsp.pready && !apb_req.pwrite;
  endsequence

  // Masked sources stay silent, since the line is only status and mask together
  a_desc_empty_quiet: assert property (p_masked_quiet(nimsk_pkg::BIT_RX_DESC_EMPTY))
    else $error("masked descriptor exhaustion interrupted");
  a_resource_empty_quiet: assert property (p_masked_quiet(nimsk_pkg::BIT_RX_RESOURCE_EMPTY))
    else $error("masked resource exhaustion interrupted");
  a_area_overrun_quiet: assert property (p_masked_quiet(nimsk_pkg::BIT_RX_AREA_OVERRUN))
    else $error("masked buffer area overrun interrupted");
  a_crc_wrap_quiet: assert property (p_masked_quiet(nimsk_pkg::BIT_CRC_TALLY_WRAP))
    else $error("masked crc tally wrap interrupted");
  a_align_wrap_quiet: assert property (p_masked_quiet(nimsk_pkg::BIT_ALIGN_TALLY_WRAP))
    else $error("masked alignment tally wrap interrupted");
  a_missed_wrap_quiet: assert property (p_masked_quiet(nimsk_pkg::BIT_MISSED_TALLY_WRAP))
    else $error("masked missed tally wrap interrupted");

  a_upper_event_irq: assert property (p_event_irq(14))
    else $error("enabled upper event did not interrupt");

  a_ack_clears_mid: assert property (p_ack_clears(nimsk_pkg::BIT_TIMER_WRAP))
    else $error("write one did not clear bit 7");

  // Set beats clear, so an event landing on its own acknowledge is not lost
  a_set_beats_clear: assert property (
    (clr_bits & ev_bits) != '0 |=>
      (interrupt_event_flags & $past(clr_bits) & $past(ev_bits)) == ($past(clr_bits) & $past(ev_bits)))
    else $error("a clear swallowed an event on the same edge");

  a_events_latch: assert property (
    ev_bits != '0 |=> (interrupt_event_flags & $past(ev_bits)) == $past(ev_bits))
    else $error("event did not latch its status bit");

  a_mask_bit_zero: assert property (
    !interrupt_enable_mask[nimsk_pkg::BIT_RESERVED])
    else $error("mask bit 15 not zero");

  a_status_read_data: assert property (
    s_read_wait ##0 hit_status |=> apb_rsp.prdata == {16'h0000, $past(interrupt_event_flags)})
    else $error("status read returned wrong data");

  a_pend_read_data: assert property (
    s_read_wait ##0 hit_pend |=>
      apb_rsp.prdata == {16'h0000, $past(interrupt_event_flags) & $past(interrupt_enable_mask)})
    else $error("pending read returned wrong data");

  // An unmapped address answers with an error and changes nothing
  a_unmapped_error: assert property (
    access && !apb_rsp.pready && !mapped |=> apb_rsp.pready && apb_rsp.pslverr)
    else $error("unmapped access did not answer with an error");

  a_mapped_no_error: assert property (
    access && !apb_rsp.pready && mapped |=> apb_rsp.pready && !apb_rsp.pslverr)
    else $error("mapped access answered with an error");

  a_unmapped_write_ignored: assert property (
    wr_done && !mapped |=>
      interrupt_event_flags == ($past(interrupt_event_flags) | $past(ev_bits)) &&
      interrupt_enable_mask == $past(interrupt_enable_mask))
    else $error("write to an unmapped address changed a register");

  a_ready_one_cycle: assert property (
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready stood longer than one cycle");

  a_ctrl_reset_pulse: assert property (
    wr_done && hit_ctrl && wr_bits[nimsk_pkg::BIT_CTRL_SW_RESET] |=> sw_reset ##1 !sw_reset)
    else $error("software reset pulse not one cycle");

  a_mask_write_lands: assert property (
    wr_done && hit_mask && apb_req.pstrb[1:0] == 2'b11 |=>
      interrupt_enable_mask == ($past(wr_bits) & nimsk_pkg::FLAGS_LIVE))
    else $error("mask write did not land");

  a_mask_kept_else: assert property (
    wr_done && !hit_mask |=> interrupt_enable_mask == $past(interrupt_enable_mask))
    else $error("mask changed by a write elsewhere");

endmodule

`default_nettype wire

// ### rtl/nimsk_pkg.sv
// Constants and types for the interrupt mask and status block
package nimsk_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned FLAG_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h05;
  localparam logic [ADDR_W-1:0] IDX_PEND = 8'h06;

  // Reset values
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] MASK_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAGS_LIVE = 16'h7fff;

  // Bit positions shared by status and mask
  localparam int unsigned BIT_RX_FIFO_OVERRUN = 0;
  localparam int unsigned BIT_MISSED_TALLY_WRAP = 1;
  localparam int unsigned BIT_ALIGN_TALLY_WRAP = 2;
  localparam int unsigned BIT_CRC_TALLY_WRAP = 3;
  localparam int unsigned BIT_RX_AREA_OVERRUN = 4;
  localparam int unsigned BIT_RX_RESOURCE_EMPTY = 5;
  localparam int unsigned BIT_RX_DESC_EMPTY = 6;
  localparam int unsigned BIT_TIMER_WRAP = 7;
  localparam int unsigned BIT_RESERVED = 15;
  localparam int unsigned BIT_CTRL_SW_RESET = 0;

  // One-cycle event pulses from the controller's units, packed as in the status register
  typedef struct packed {
    logic bus_retry_flag;
    logic heartbeat_lost_flag;
    logic cam_load_done_flag;
    logic prog_interrupt_flag;
    logic packet_received_flag;
    logic tx_done_flag;
    logic tx_error_flag;
    logic timer_wrap_flag;
    logic rx_desc_empty_flag;
    logic rx_resource_empty_flag;
    logic rx_area_overrun_flag;
    logic crc_tally_wrap_flag;
    logic align_tally_wrap_flag;
    logic missed_tally_wrap_flag;
    logic rx_fifo_overrun_flag;
  } nimsk_events_t;

  // APB request and answer groups
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0] pstrb;
  } nimsk_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } nimsk_apb_rsp_t;

endpackage

// ### bench/nimsk_host.sv
// Host model: APB master that reads, writes and acknowledges interrupt flags
`timescale 1ns/1ps
`default_nettype none
module nimsk_host (
  // Clock
  input wire logic sys_clk,
  // APB master side
  output var nimsk_pkg::nimsk_apb_req_t apb_req,
  input wire nimsk_pkg::nimsk_apb_rsp_t apb_rsp
);
  initial apb_req = '0;

  // No latency assumed; the bench watchdog ends a hung wait
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] strb,
                      output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd, pstrb: strb};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic ack(input logic [15:0] bits);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, 8'(nimsk_pkg::IDX_STATUS * 4), {16'h0000, bits}, 4'hf, rd, err);
  endtask
endmodule
`default_nettype wire

// ### bench/net_ctrl_interrupt_mask_status_tb.sv
// Self-checking bench for the interrupt mask and status block
`timescale 1ns/1ps
`default_nettype none
module net_ctrl_interrupt_mask_status_tb;
  localparam logic [7:0] A_CTRL = 8'(nimsk_pkg::IDX_CTRL * 4);
  localparam logic [7:0] A_MASK = 8'(nimsk_pkg::IDX_MASK * 4);
  localparam logic [7:0] A_STAT = 8'(nimsk_pkg::IDX_STATUS * 4);
  localparam logic [7:0] A_HOLE = 8'h08;
  localparam logic [7:0] A_PEND = 8'(nimsk_pkg::IDX_PEND * 4);
  logic sys_clk, rst, irq, sw_reset, err;
  nimsk_pkg::nimsk_apb_req_t apb_req;
  nimsk_pkg::nimsk_apb_rsp_t apb_rsp;
  nimsk_pkg::nimsk_events_t events;
  logic [31:0] rd;
  int failures, n_tests, sw_pulses;

  nimsk_irq uut (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
                 .events(events), .irq(irq), .sw_reset(sw_reset));
  nimsk_host u_host (.sys_clk(sys_clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) if (sw_reset === 1'b1) sw_pulses++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, 4'hf, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0, 4'h0, rd, err);
    chk(rd, exp);
  endtask

  // Settle past the edge before looking at the level
  task automatic irq_chk(input logic exp);
    @(posedge sys_clk);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic pulse(input int b);
    @(posedge sys_clk);
    events <= nimsk_pkg::nimsk_events_t'(15'h0001 << b);
    @(posedge sys_clk);
    events <= '0;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100us;
    failures++;
    tally_and_finish;
  end

  initial begin
    rst = 1'b1;
    events = '0;
    failures = 0;
    n_tests = 0;
    sw_pulses = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(A_STAT, 32'h0);
    rd_chk(A_MASK, 32'h0);
    // Every source: masked, enabled, cleared, then raised again behind an open mask
    for (int b = 0; b < 15; b++) begin
      wr(A_MASK, 32'h0);
      pulse(b);
      rd_chk(A_STAT, 32'h1 << b);
      irq_chk(1'b0);
      wr(A_MASK, 32'h1 << b);
      irq_chk(1'b1);
      wr(A_STAT, 32'h0);
      rd_chk(A_STAT, 32'h1 << b);
      u_host.ack(16'(32'h1 << b));
      rd_chk(A_STAT, 32'h0);
      irq_chk(1'b0);
      pulse(b);
      irq_chk(1'b1);
      u_host.ack(16'(32'h1 << b));
    end
    wr(A_MASK, 32'hffff);
    rd_chk(A_MASK, 32'h7fff);
    // Only byte lane 0 written: the upper mask byte keeps its ones
    u_host.xfer(1'b1, A_MASK, 32'h0, 4'h1, rd, err);
    rd_chk(A_MASK, 32'h7f00);
    pulse(3);
    pulse(9);
    rd_chk(A_PEND, 32'h200);
    wr(A_STAT, 32'h8);
    rd_chk(A_STAT, 32'h200);
    // A one in a lane that is not strobed clears nothing
    u_host.xfer(1'b1, A_STAT, 32'h200, 4'h1, rd, err);
    rd_chk(A_STAT, 32'h200);
    irq_chk(1'b1);
    wr(A_CTRL, 32'h1);
    rd_chk(A_STAT, 32'h200);
    chk(32'(sw_pulses), 32'h1);
    // An event landing on the edge of its own acknowledge survives it
    fork
      u_host.ack(16'h0200);
      begin
        repeat (3) @(posedge sys_clk);
        events <= nimsk_pkg::nimsk_events_t'(15'h0200);
        @(posedge sys_clk);
        events <= '0;
      end
    join
    rd_chk(A_STAT, 32'h200);
    u_host.xfer(1'b0, A_HOLE, 32'h0, 4'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    u_host.xfer(1'b1, A_HOLE, 32'hffff, 4'hf, rd, err);
    chk({31'h0, err}, 32'h1);
    rd_chk(A_MASK, 32'h7f00);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(A_STAT, 32'h0);
    rd_chk(A_MASK, 32'h0);
    irq_chk(1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
